/* pkg/bstp_map.svh */
// Purpose: constants of the boundary-scan test port
// Assumes: 3-bit instructions, 32-bit identification code
// Notes: identification value is arbitrary
`ifndef BSTP_MAP_SVH
`define BSTP_MAP_SVH
`define BSTP_IR_W 3
`define BSTP_OP_EXTEST 3'h0
`define BSTP_OP_IDREAD 3'h1
`define BSTP_OP_HIZSAMPLE 3'h2
`define BSTP_OP_SAMPLE 3'h4
`define BSTP_OP_BYPASS 3'h7
`define BSTP_IR_CAPTURE 3'h1
`define BSTP_ID_W 32
`define BSTP_ID_VALUE 32'h1234_5671
`define BSTP_BSR_W 8
`define BSTP_FIFO_DEPTH 8
`endif

/* pkg/bstp_pkg.sv */
// Purpose: types of the boundary-scan test port
// Assumes: none
// Notes: sixteen-state controller
package bstp_pkg;
  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
    ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
    ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } bstp_state_type;
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bstp_pins_type;
  typedef struct packed {
    logic [2:0] tck_s;
    logic [2:0] tms_s;
    logic [2:0] tdi_s;
    logic tck_lvl;
    bstp_state_type st;
    logic [2:0] ir;
    logic [2:0] ir_act;
    logic [2:0] ir_sh;
    logic byp;
    logic [31:0] id;
    logic [7:0] bsr;
    logic [7:0] bsr_upd;
    logic sdo_bit;
    logic tdo;
    logic tdo_oe;
    logic hiz;
  } bstp_core_type;
  typedef struct packed {
    logic [2:0] wr_ptr;
    logic [2:0] rd_ptr;
    logic [3:0] cnt;
  } bstp_fifo_type;
endpackage : bstp_pkg

/* src/bstp_top.sv */
// Purpose: boundary-scan test port sampled on the system clock
// Assumes: test clock far slower than clk (200 ns vs 25 ns)
// Notes: serial output bits also stream into a small buffer
`timescale 1ns/1ps
`include "bstp_map.svh"

module bstp_fifo
  import bstp_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter int DEPTH = `BSTP_FIFO_DEPTH
)(
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, low
  input wire logic [WIDTH-1:0] in_data, // write data
  input wire logic in_valid, // write request
  output logic in_ready, // room available
  output logic [WIDTH-1:0] out_data, // head word
  output logic out_valid, // head present
  input wire logic out_ready // drain accepts
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  bstp_fifo_type s_q, s_d;
  logic wr, rd;
  assign in_ready = (s_q.cnt != 4'(DEPTH));
  assign out_valid = (s_q.cnt != 4'h0);
  assign out_data = mem_q[s_q.rd_ptr];
  assign wr = in_valid && in_ready;
  assign rd = out_valid && out_ready;
  always_comb
  begin
    s_d = s_q;
    if (wr)
      s_d.wr_ptr = 3'(s_q.wr_ptr + 3'h1);
    if (rd)
      s_d.rd_ptr = 3'(s_q.rd_ptr + 3'h1);
    s_d.cnt = 4'(s_q.cnt + {3'h0, wr} - {3'h0, rd});
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      s_q <= '0;
    else
      s_q <= s_d;
  end
  always_ff @(posedge clk)
  begin
    if (wr)
      mem_q[s_q.wr_ptr] <= in_data;
  end
endmodule : bstp_fifo

////////////////////////////////////////////////////////////////////////////
module bstp_top
  import bstp_pkg::*;
#(
  parameter int BSR_W = `BSTP_BSR_W,
  parameter logic [31:0] ID_CODE = `BSTP_ID_VALUE // arbitrary value
)(
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, low (power-up)
  input wire bstp_pins_type pins, // test clock, mode, data in
  input wire logic [BSR_W-1:0] pin_levels, // levels on pins, 1 if no pin
  output logic tdo, // serial data out
  output logic tdo_oe, // serial out enable
  output logic mem_out_hiz, // forces memory drivers off
  output logic [BSR_W-1:0] bsr_drive, // extest drive values
  output logic extest_on, // extest drive active
  output logic stream_bit, // captured shift-out bit
  output logic stream_valid, // stream bit present
  input wire logic stream_ready // stream drain accepts
);
  bstp_core_type s_q, s_d;
  logic [BSR_W-1:0] bsr_q, bsr_d, bsr_upd_q, bsr_upd_d;
  logic rise, fall, tms_v, tdi_v, fifo_in_ready, push;

  function automatic bstp_state_type next_st(bstp_state_type s, logic m);
    unique case (s)
      ST_RESET: next_st = m ? ST_RESET : ST_IDLE;
      ST_IDLE: next_st = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: next_st = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_st = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: next_st = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: next_st = m ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: next_st = m ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: next_st = m ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: next_st = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: next_st = m ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: next_st = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: next_st = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: next_st = m ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: next_st = m ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: next_st = m ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: next_st = m ? ST_SEL_DR : ST_IDLE;
    endcase
  endfunction : next_st

  function automatic logic is_bsr_op(logic [2:0] op);
    is_bsr_op = (op == `BSTP_OP_EXTEST) || (op == `BSTP_OP_SAMPLE) ||
      (op == `BSTP_OP_HIZSAMPLE);
  endfunction : is_bsr_op

  // test clock level accepted when second and third stage agree
  assign rise = (s_q.tck_s[1] == s_q.tck_s[2]) && s_q.tck_s[2] && !s_q.tck_lvl;
  assign fall = (s_q.tck_s[1] == s_q.tck_s[2]) && !s_q.tck_s[2] && s_q.tck_lvl;
  // glitch on mode or data only between stages is tolerated by slow clock
  assign tms_v = s_q.tms_s[2];
  assign tdi_v = s_q.tdi_s[2];
  // push follows the shift state, not the old enable, so bit 0 is kept
  assign push = fall && fifo_in_ready &&
    ((s_q.st == ST_SHIFT_DR) || (s_q.st == ST_SHIFT_IR));

  always_comb
  begin
    s_d = s_q;
    bsr_d = bsr_q;
    bsr_upd_d = bsr_upd_q;
    s_d.tck_s = {s_q.tck_s[1:0], pins.tck};
    s_d.tms_s = {s_q.tms_s[1:0], pins.tms};
    s_d.tdi_s = {s_q.tdi_s[1:0], pins.tdi};
    if (s_q.tck_s[1] == s_q.tck_s[2])
      s_d.tck_lvl = s_q.tck_s[2];
    // no edges, no state change: port stays quiet
    if (rise)
    begin
      s_d.st = next_st(s_q.st, tms_v);
      unique case (s_q.st)
        ST_RESET:
        begin
          s_d.ir = `BSTP_OP_IDREAD;
          s_d.ir_act = `BSTP_OP_IDREAD;
        end
        ST_CAP_IR: s_d.ir_sh = `BSTP_IR_CAPTURE;
        ST_SHIFT_IR: s_d.ir_sh = {tdi_v, s_q.ir_sh[2:1]};
        ST_UPD_IR: s_d.ir = s_q.ir_sh;
        ST_CAP_DR:
        begin
          if (s_q.ir_act == `BSTP_OP_IDREAD)
            s_d.id = ID_CODE;
          else if (is_bsr_op(s_q.ir_act))
            bsr_d = pin_levels;
          else
            s_d.byp = 1'b0;
        end
        ST_SHIFT_DR:
        begin
          if (s_q.ir_act == `BSTP_OP_IDREAD)
            s_d.id = {tdi_v, s_q.id[31:1]};
          else if (is_bsr_op(s_q.ir_act))
            bsr_d = {tdi_v, bsr_q[BSR_W-1:1]};
          else
            s_d.byp = tdi_v;
        end
        ST_UPD_DR:
        begin
          if (is_bsr_op(s_q.ir_act))
            bsr_upd_d = bsr_q;
        end
        default:
        begin
        end
      endcase
      // new instruction acts from idle or the data column on
      if (s_d.st == ST_IDLE || s_d.st == ST_SEL_DR)
        s_d.ir_act = (s_q.st == ST_UPD_IR) ? s_q.ir_sh : s_d.ir;
      if (s_d.st == ST_RESET)
      begin
        s_d.ir = `BSTP_OP_IDREAD;
        s_d.ir_act = `BSTP_OP_IDREAD;
      end
    end
    if (fall)
    begin
      s_d.tdo_oe = (s_q.st == ST_SHIFT_DR) || (s_q.st == ST_SHIFT_IR);
      if (s_q.st == ST_SHIFT_IR)
        s_d.tdo = s_q.ir_sh[0];
      else if (s_q.ir_act == `BSTP_OP_IDREAD)
        s_d.tdo = s_q.id[0];
      else if (is_bsr_op(s_q.ir_act))
        s_d.tdo = bsr_q[0];
      else
        s_d.tdo = s_q.byp;
      s_d.sdo_bit = s_d.tdo;
      s_d.hiz = (s_q.ir_act == `BSTP_OP_HIZSAMPLE);
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
      s_q.tck_s <= 3'h0;
      s_q.tms_s <= 3'h7;
      s_q.tdi_s <= 3'h7;
      s_q.st <= ST_RESET;
      s_q.ir <= `BSTP_OP_IDREAD;
      s_q.ir_act <= `BSTP_OP_IDREAD;
      s_q.ir_sh <= `BSTP_IR_CAPTURE;
      bsr_q <= '0;
      bsr_upd_q <= '0;
    end
    else
    begin
      s_q <= s_d;
      bsr_q <= bsr_d;
      bsr_upd_q <= bsr_upd_d;
    end
  end

  assign tdo = s_q.tdo;
  assign tdo_oe = s_q.tdo_oe;
  assign mem_out_hiz = s_q.hiz;
  assign bsr_drive = bsr_upd_q;

  logic ext_q;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ext_q <= 1'b0;
    else if (fall)
      ext_q <= (s_q.ir_act == `BSTP_OP_EXTEST);
  end
  assign extest_on = ext_q;

  // stream drops bits when full; the tester clock cannot be stalled
  bstp_fifo #(.WIDTH(1), .DEPTH(`BSTP_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_data(s_d.sdo_bit),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .out_data(stream_bit),
    .out_valid(stream_valid),
    .out_ready(stream_ready)
  );
endmodule : bstp_top

/* test/bstp_ctl.sv */
// Purpose: board-level scan controller model
// Assumes: step is entered on a clk rising edge
// Notes: tck rests low between bits
`timescale 1ns/1ps
module bstp_ctl
  import bstp_pkg::*;
(
  input wire logic clk, // system clock
  output bstp_pins_type pins, // test clock, mode, data in
  input wire logic tdo, // serial out
  input wire logic tdo_oe // serial out enable
);
  logic last = 1'b0;
  initial
    pins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};
  // tdo read late in the high phase, long after the fall that set it
  task automatic step(input logic ms, input logic di, output logic b);
    pins.tms <= ms;
    pins.tdi <= di;
    repeat (4) @(posedge clk);
    pins.tck <= 1'b1;
    repeat (4) @(posedge clk);
    b = tdo_oe ? tdo : ~last;
    last = b;
    pins.tck <= 1'b0;
  endtask : step
endmodule : bstp_ctl

/* test/bstp_top_assertions.sv */
// Purpose: port checks of the test port
// Assumes: test pins change on clk edges
// Notes: ages count clk cycles since tck edges
`timescale 1ns/1ps
module bstp_top_assertions
  import bstp_pkg::*;
#(
  parameter int BSR_W = 8
)(
  input wire logic clk, // system clock
  input wire logic rstn, // async reset, low
  input wire bstp_pins_type pins, // test pins
  input wire logic tdo, // serial out
  input wire logic tdo_oe, // out enable
  input wire logic mem_out_hiz, // outputs off
  input wire logic [BSR_W-1:0] bsr_drive, // drive values
  input wire logic extest_on // drive active
);
  logic tq, mq, sq;
  logic [3:0] fa, ea, ones;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tq <= 1'b0;
      mq <= 1'b0;
      sq <= 1'b0;
      fa <= 4'hf;
      ea <= 4'hf;
      ones <= 4'h0;
    end
    else
    begin
      tq <= pins.tck;
      sq <= sq | (tq != pins.tck);
      ea <= (tq != pins.tck) ? 4'h1 : ea + 4'(ea != 4'hf);
      fa <= (tq && !pins.tck) ? 4'h1 : fa + 4'(fa != 4'hf);
      if (!tq && pins.tck)
        mq <= pins.tms;
      // counted at falls so the check waits for the output update
      if (tq && !pins.tck)
        ones <= mq ? ones + 4'(ones != 4'hf) : 4'h0;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  property p_tdo; $changed(tdo) |-> fa inside {[2:6]}; endproperty
  a_tdo: assert property (p_tdo) else $error("tdo off fall");
  property p_oe; $changed(tdo_oe) |-> fa inside {[2:6]}; endproperty
  a_oe: assert property (p_oe) else $error("oe off fall");
  property p_hiz; $changed(mem_out_hiz) |-> fa inside {[2:6]}; endproperty
  a_hiz: assert property (p_hiz) else $error("hiz off fall");
  property p_ext; $changed(extest_on) |-> ea inside {[1:7]}; endproperty
  a_ext: assert property (p_ext) else $error("ext no tck");
  property p_drv; $changed(bsr_drive) |-> ea inside {[1:7]}; endproperty
  a_drv: assert property (p_drv) else $error("drv no tck");
  property p_quiet; !sq |-> !(tdo_oe | mem_out_hiz | extest_on); endproperty
  a_quiet: assert property (p_quiet) else $error("not quiet");
  property p_five;
    ones >= 4'h5 && fa == 4'h6 |-> !(tdo_oe | mem_out_hiz | extest_on);
  endproperty
  a_five: assert property (p_five) else $error("no reset");
  property p_one; !(mem_out_hiz && extest_on); endproperty
  a_one: assert property (p_one) else $error("two modes");
endmodule : bstp_top_assertions
bind bstp_top bstp_top_assertions #(.BSR_W(BSR_W)) chk (.clk(clk),
  .rstn(rstn), .pins(pins), .tdo(tdo), .tdo_oe(tdo_oe),
  .mem_out_hiz(mem_out_hiz), .bsr_drive(bsr_drive), .extest_on(extest_on));

/* test/tb_top.sv */
// Purpose: self-checking bench of the test port
// Assumes: tck of 200 ns made by the controller model
// Notes: stream buffer stays stalled through the first id read
`timescale 1ns/1ps
`include "bstp_map.svh"
module tb_top
  import bstp_pkg::*;
  ();
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic rdy = 1'b0;
  logic [7:0] lvl = 8'h00;
  bstp_pins_type pins;
  logic tdo, oe, hiz, ext, sbit, sval;
  logic [7:0] drv;
  logic [31:0] id = `BSTP_ID_VALUE;
  int num_errors = 0;
  int checks_done = 0;
  always #12.5 clk = ~clk;
  bstp_ctl ctl (.clk(clk), .pins(pins), .tdo(tdo), .tdo_oe(oe));
  bstp_top dut (.clk(clk), .rstn(rstn), .pins(pins), .pin_levels(lvl),
    .tdo(tdo), .tdo_oe(oe), .mem_out_hiz(hiz), .bsr_drive(drv),
    .extest_on(ext), .stream_bit(sbit), .stream_valid(sval),
    .stream_ready(rdy));
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task automatic go(input logic [7:0] v, input int n);
    logic b;
    for (int i = 0; i < n; i++)
      ctl.step(v[i], 1'b1, b);
  endtask : go
  task automatic shift(input int n, input logic [31:0] di,
    output logic [31:0] q);
    logic b;
    q = '0;
    for (int i = 0; i < n; i++)
    begin
      ctl.step(i == n - 1, di[i], b);
      q[i] = b;
    end
  endtask : shift
  task automatic ir(input logic [2:0] op);
    logic [31:0] q;
    go(8'h03, 4);
    shift(3, {29'h0, op}, q);
    cmp(q[1:0], 2'h1);
    go(8'h01, 2);
  endtask : ir
  task automatic id_read();
    logic [31:0] q;
    go(8'h02, 4);
    shift(32, 32'hffff_ffff, q);
    cmp(q, id);
    go(8'h01, 2);
  endtask : id_read
  ////////////////////////////////////////////////////////////////////////
  initial
  begin : main
    logic [31:0] q;
    logic [31:0] d;
    logic [2:0] op;
    d = $urandom(32'h6fda);
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(posedge clk);
    cmp({oe, hiz, ext}, 3'h0);
    id_read();
    // buffer refused all but the first eight bits
    for (int i = 0; i < 8; i++)
    begin
      @(negedge clk);
      cmp({sval, sbit}, {1'b1, id[i]});
      @(posedge clk);
      rdy <= 1'b1;
      @(posedge clk);
      rdy <= 1'b0;
    end
    @(negedge clk);
    cmp(sval, 1'b0);
    @(posedge clk);
    for (int k = 0; k < 8; k++)
    begin
      op = 3'(k);
      lvl <= 8'($urandom) | 8'h80;
      d = $urandom;
      ir(op);
      go(8'h01, 3);
      shift(16, d, q);
      go(8'h01, 2);
      repeat (8) @(posedge clk);
      if (op inside {`BSTP_OP_EXTEST, `BSTP_OP_HIZSAMPLE, `BSTP_OP_SAMPLE})
      begin
        cmp(q[15:0], {d[7:0], lvl});
        cmp({oe, hiz, ext, drv}, {1'b0, op == `BSTP_OP_HIZSAMPLE,
          op == `BSTP_OP_EXTEST, d[15:8]});
      end
      else if (op == `BSTP_OP_IDREAD)
        cmp(q[15:0], id[15:0]);
      else
        cmp(q[15:1], d[14:0]);
    end
    go(8'h01, 3);
    go(8'h1f, 5);
    id_read();
    print_verdict();
  end
  initial
  begin : watchdog
    #400_000;
    num_errors++;
    print_verdict();
  end
endmodule : tb_top
